/* pemux_port_e.sv */
// Port E alternate-function multiplexer with its AHB-Lite register slave
//
// Contract
// - Port E bits 1 to 7 are general IO or their alternate function per the alt-select bit.
// - The timer-1 overflow pin is high for the clock-output cycle after each clock-output cycle that saw a timer-1 overflow.
// - In timer-1 mode 3 the overflow pulse comes from the low byte counter.
// - The timer-2 overflow pin is high for one clock cycle per timer-2 overflow.
// - Serial 0 sync output carries unit data only in mode 0, else holds 1.
// - Serial 1 sync output carries unit data only in mode 0, else is high.
// - External interrupt 6 requests on a rising edge, active high.
// - A falling edge on the timer-2 reload input reloads timer 2.
// - The timer-2 reload input is ignored unless the timer-2 external enable is set.
// - In slave FIFO mode ready pin 0 is the read strobe, polarity from polarity bit 3.
// - In slave FIFO mode ready pin 1 is the write strobe, polarity from polarity bit 2.
// - Ready pins 2 to 5 are plain waveform engine inputs with no alternate function.
// - Port E bit 7 in alternate mode drives the waveform engine address bit 8.
`timescale 1ns/10ps
module pemux_port_e
    import pemux_pkg::*;
#(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt
    output logic irq,
    // Port E pins, split into input, output and output enable
    input wire logic [PIN_COUNT-1:0] port_e_in,
    output logic [PIN_COUNT-1:0] port_e_out,
    output logic [PIN_COUNT-1:0] port_e_oe,
    // Ready pins
    input wire logic [5:0] waveform_ready_pins,
    // Core-side sources, same clock
    input wire logic clock_output_tick,
    input wire logic timer1_overflow,
    input wire logic timer1_low_byte_overflow,
    input wire logic timer1_mode3,
    input wire logic timer2_overflow,
    input wire logic [1:0] serial0_mode,
    input wire logic serial0_tx_data,
    input wire logic [1:0] serial1_mode,
    input wire logic serial1_tx_data,
    input wire logic waveform_addr_bit8,
    // Core-side results
    output logic ext_irq6_input,
    output logic timer2_reload,
    output logic fifo_read_strobe,
    output logic fifo_write_strobe,
    output logic [5:0] waveform_ready_in
);

    typedef struct packed {
        logic [7:0] port_e_alt_select;
        logic [7:0] port_out;
        logic [7:0] port_oe;
        logic [7:0] timer2_control;
        logic [7:0] fifo_pin_polarity;
        logic [7:0] interface_config;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [7:0] wr_addr;
        logic wr_pend;
        logic [7:0] rd_addr;
        logic rd_pend;
        logic [31:0] rdata;
        logic [PIN_COUNT-1:0] pin_s1;
        logic [PIN_COUNT-1:0] pin_s2;
        logic [PIN_COUNT-1:0] pin_prev;
        logic [5:0] rdy_s1;
        logic [5:0] rdy_s2;
        logic [1:0] rdy_prev;
        logic t1_pending;
        logic t1_pulse;
        logic t2_pulse;
        logic irq6;
        logic reload;
        logic rd_strobe;
        logic wr_strobe;
    } pemux_state_type;

    pemux_state_type state_q;
    pemux_state_type state_d;
    logic t1_event;
    logic [PIN_COUNT-1:0] alt_out;
    logic [PIN_COUNT-1:0] alt_oe;
    logic slave_fifo;
    logic rd_level;
    logic wr_level;
    logic rd_prev_level;
    logic wr_prev_level;

    ////////////////////////////////////////////////////////////////////////////
    // Alternate pin drive
    always_comb begin
        t1_event = timer1_mode3 ? timer1_low_byte_overflow : timer1_overflow;
        alt_out = state_q.port_out;
        alt_oe = state_q.port_oe;
        alt_out[PEMUX_PIN_T1OVF] = state_q.t1_pulse;
        alt_out[PEMUX_PIN_T2OVF] = state_q.t2_pulse;
        alt_out[PEMUX_PIN_SER0] = (serial0_mode == PEMUX_SERIAL_MODE_SYNC) ?
            serial0_tx_data : 1'b1;
        alt_out[PEMUX_PIN_SER1] = (serial1_mode == PEMUX_SERIAL_MODE_SYNC) ?
            serial1_tx_data : 1'b1;
        alt_out[PEMUX_PIN_ADDR8] = waveform_addr_bit8;
        alt_oe[PEMUX_PIN_T1OVF] = 1'b1;
        alt_oe[PEMUX_PIN_T2OVF] = 1'b1;
        alt_oe[PEMUX_PIN_SER0] = 1'b1;
        alt_oe[PEMUX_PIN_SER1] = 1'b1;
        alt_oe[PEMUX_PIN_EXT6] = 1'b0;
        alt_oe[PEMUX_PIN_T2RELOAD] = 1'b0;
        alt_oe[PEMUX_PIN_ADDR8] = 1'b1;
    end

    // Bit 0 stays general IO; its alternate lies outside this block
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
            if (gi == 0) begin : g_gpio
                assign port_e_out[gi] = state_q.port_out[gi];
                assign port_e_oe[gi] = state_q.port_oe[gi];
            end else begin : g_mux
                assign port_e_out[gi] = state_q.port_e_alt_select[gi] ?
                    alt_out[gi] : state_q.port_out[gi];
                assign port_e_oe[gi] = state_q.port_e_alt_select[gi] ?
                    alt_oe[gi] : state_q.port_oe[gi];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Strobe polarity: polarity bit set means active high
    assign slave_fifo = state_q.interface_config[PEMUX_IFCFG_SLAVE_FIFO_BIT];
    assign rd_level = state_q.rdy_s2[0] ~^ state_q.fifo_pin_polarity[PEMUX_POL_READ_BIT];
    assign wr_level = state_q.rdy_s2[1] ~^ state_q.fifo_pin_polarity[PEMUX_POL_WRITE_BIT];
    assign rd_prev_level = state_q.rdy_prev[0] ~^ state_q.fifo_pin_polarity[PEMUX_POL_READ_BIT];
    assign wr_prev_level = state_q.rdy_prev[1] ~^ state_q.fifo_pin_polarity[PEMUX_POL_WRITE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_d = state_q;
        state_d.pin_s1 = port_e_in;
        state_d.pin_s2 = state_q.pin_s1;
        state_d.pin_prev = state_q.pin_s2;
        state_d.rdy_s1 = waveform_ready_pins;
        state_d.rdy_s2 = state_q.rdy_s1;
        state_d.rdy_prev = state_q.rdy_s2[1:0];

        // Hold the overflow until the clock-output cycle starts, then pulse for it
        if (clock_output_tick) begin
            state_d.t1_pulse = state_q.t1_pending || t1_event;
            state_d.t1_pending = 1'b0;
        end else if (t1_event) begin
            state_d.t1_pending = 1'b1;
        end
        state_d.t2_pulse = timer2_overflow;

        state_d.irq6 = state_q.port_e_alt_select[PEMUX_PIN_EXT6] &&
            state_q.pin_s2[PEMUX_PIN_EXT6] && !state_q.pin_prev[PEMUX_PIN_EXT6];
        state_d.reload = state_q.port_e_alt_select[PEMUX_PIN_T2RELOAD] &&
            state_q.timer2_control[PEMUX_TIMER2_CONTROL_EXT_ENABLE_BIT] &&
            !state_q.pin_s2[PEMUX_PIN_T2RELOAD] && state_q.pin_prev[PEMUX_PIN_T2RELOAD];
        state_d.rd_strobe = slave_fifo && rd_level && !rd_prev_level;
        state_d.wr_strobe = slave_fifo && wr_level && !wr_prev_level;

        // AHB address phase
        state_d.wr_pend = 1'b0;
        state_d.rd_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            state_d.wr_pend = hwrite;
            state_d.rd_pend = !hwrite;
            state_d.wr_addr = haddr[7:0];
            state_d.rd_addr = haddr[7:0];
        end

        // AHB write data phase
        if (state_q.wr_pend) begin
            if (state_q.wr_addr == PEMUX_ADDR_ALT_SELECT) begin
                state_d.port_e_alt_select = hwdata[7:0];
            end else if (state_q.wr_addr == PEMUX_ADDR_PORT_OUT) begin
                state_d.port_out = hwdata[7:0];
            end else if (state_q.wr_addr == PEMUX_ADDR_PORT_OE) begin
                state_d.port_oe = hwdata[7:0];
            end else if (state_q.wr_addr == PEMUX_ADDR_TIMER2_CONTROL) begin
                state_d.timer2_control = hwdata[7:0];
            end else if (state_q.wr_addr == PEMUX_ADDR_FIFO_POLARITY) begin
                state_d.fifo_pin_polarity = hwdata[7:0];
            end else if (state_q.wr_addr == PEMUX_ADDR_IFACE_CONFIG) begin
                state_d.interface_config = hwdata[7:0];
            end else if (state_q.wr_addr == PEMUX_ADDR_IRQ_MASK) begin
                state_d.irq_mask = hwdata[7:0];
            end
        end

        // Read data is captured at the address phase so it is a flop in the data phase
        state_d.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[7:0] == PEMUX_ADDR_ALT_SELECT) begin
                state_d.rdata = {24'h00_0000, state_q.port_e_alt_select};
            end else if (haddr[7:0] == PEMUX_ADDR_PORT_OUT) begin
                state_d.rdata = {24'h00_0000, state_q.port_out};
            end else if (haddr[7:0] == PEMUX_ADDR_PORT_OE) begin
                state_d.rdata = {24'h00_0000, state_q.port_oe};
            end else if (haddr[7:0] == PEMUX_ADDR_PORT_IN) begin
                state_d.rdata = {24'h00_0000, state_q.pin_s2};
            end else if (haddr[7:0] == PEMUX_ADDR_TIMER2_CONTROL) begin
                state_d.rdata = {24'h00_0000, state_q.timer2_control};
            end else if (haddr[7:0] == PEMUX_ADDR_FIFO_POLARITY) begin
                state_d.rdata = {24'h00_0000, state_q.fifo_pin_polarity};
            end else if (haddr[7:0] == PEMUX_ADDR_IFACE_CONFIG) begin
                state_d.rdata = {24'h00_0000, state_q.interface_config};
            end else if (haddr[7:0] == PEMUX_ADDR_IRQ_STATUS) begin
                state_d.rdata = {24'h00_0000, state_q.irq_status};
            end else if (haddr[7:0] == PEMUX_ADDR_IRQ_MASK) begin
                state_d.rdata = {24'h00_0000, state_q.irq_mask};
            end else if (haddr[7:0] == PEMUX_ADDR_READY_IN) begin
                state_d.rdata = {26'h000_0000, state_q.rdy_s2};
            end
        end

        // Status clears on read; a same-cycle event still sets
        if (state_q.rd_pend && state_q.rd_addr == PEMUX_ADDR_IRQ_STATUS) begin
            state_d.irq_status = 8'h00;
        end
        if (state_q.irq6) begin
            state_d.irq_status[PEMUX_IRQ_EXT6_BIT] = 1'b1;
        end
        if (state_q.reload) begin
            state_d.irq_status[PEMUX_IRQ_T2RELOAD_BIT] = 1'b1;
        end
        if (state_q.rd_strobe) begin
            state_d.irq_status[PEMUX_IRQ_FIFO_RD_BIT] = 1'b1;
        end
        if (state_q.wr_strobe) begin
            state_d.irq_status[PEMUX_IRQ_FIFO_WR_BIT] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= '0;
            state_q.port_e_alt_select <= PEMUX_ALT_SELECT_RESET;
            state_q.port_oe <= PEMUX_PORT_OE_RESET;
            state_q.port_out <= PEMUX_PORT_OUT_RESET;
            state_q.irq_mask <= PEMUX_REG_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hrdata = state_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(state_q.irq_status & state_q.irq_mask);
    assign ext_irq6_input = state_q.irq6;
    assign timer2_reload = state_q.reload;
    assign fifo_read_strobe = state_q.rd_strobe;
    assign fifo_write_strobe = state_q.wr_strobe;
    // Ready pins pass through synchronised, never rerouted
    assign waveform_ready_in = state_q.rdy_s2;

endmodule : pemux_port_e

/* pemux_pkg.sv */
// Package for the port E alternate-function pin multiplexer
package pemux_pkg;

    // Register byte addresses
    localparam logic [7:0] PEMUX_ADDR_ALT_SELECT = 8'h00;
    localparam logic [7:0] PEMUX_ADDR_PORT_OUT = 8'h04;
    localparam logic [7:0] PEMUX_ADDR_PORT_OE = 8'h08;
    localparam logic [7:0] PEMUX_ADDR_PORT_IN = 8'h0c;
    localparam logic [7:0] PEMUX_ADDR_TIMER2_CONTROL = 8'h10;
    localparam logic [7:0] PEMUX_ADDR_FIFO_POLARITY = 8'h14;
    localparam logic [7:0] PEMUX_ADDR_IFACE_CONFIG = 8'h18;
    localparam logic [7:0] PEMUX_ADDR_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] PEMUX_ADDR_IRQ_MASK = 8'h20;
    localparam logic [7:0] PEMUX_ADDR_READY_IN = 8'h24;

    // Field positions
    localparam int PEMUX_TIMER2_CONTROL_EXT_ENABLE_BIT = 3;
    localparam int PEMUX_POL_READ_BIT = 3;
    localparam int PEMUX_POL_WRITE_BIT = 2;
    localparam int PEMUX_IFCFG_SLAVE_FIFO_BIT = 0;
    localparam int PEMUX_IRQ_EXT6_BIT = 0;
    localparam int PEMUX_IRQ_T2RELOAD_BIT = 1;
    localparam int PEMUX_IRQ_FIFO_RD_BIT = 2;
    localparam int PEMUX_IRQ_FIFO_WR_BIT = 3;

    // Pin positions on port E
    localparam int PEMUX_PIN_T1OVF = 1;
    localparam int PEMUX_PIN_T2OVF = 2;
    localparam int PEMUX_PIN_SER0 = 3;
    localparam int PEMUX_PIN_SER1 = 4;
    localparam int PEMUX_PIN_EXT6 = 5;
    localparam int PEMUX_PIN_T2RELOAD = 6;
    localparam int PEMUX_PIN_ADDR8 = 7;

    // Reset values: all pins general IO, inputs
    localparam logic [7:0] PEMUX_ALT_SELECT_RESET = 8'h00;
    localparam logic [7:0] PEMUX_PORT_OE_RESET = 8'h00;
    localparam logic [7:0] PEMUX_PORT_OUT_RESET = 8'h00;
    localparam logic [7:0] PEMUX_REG_RESET = 8'h00;
    localparam logic [1:0] PEMUX_SERIAL_MODE_SYNC = 2'h0;

endpackage : pemux_pkg

/* pemux_port_e_monitor.sv */
// Port-level checker for the port E pin multiplexer
`timescale 1ns/10ps
module pemux_port_e_monitor
    import pemux_pkg::*;
#(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Pins
    input wire logic [PIN_COUNT-1:0] port_e_out,
    input wire logic [PIN_COUNT-1:0] port_e_oe,
    input wire logic [5:0] waveform_ready_pins,
    // Core side
    input wire logic timer2_overflow,
    input wire logic [1:0] serial0_mode,
    input wire logic serial0_tx_data,
    input wire logic [1:0] serial1_mode,
    input wire logic serial1_tx_data,
    input wire logic waveform_addr_bit8,
    input wire logic clock_output_tick,
    input wire logic timer1_overflow,
    input wire logic timer1_low_byte_overflow,
    input wire logic timer1_mode3,
    input wire logic ext_irq6_input,
    input wire logic timer2_reload,
    input wire logic fifo_read_strobe,
    input wire logic [5:0] waveform_ready_in
);
    // Shadow of the alt-select register, so pin checks know which function is live
    logic wr_q;
    logic [7:0] alt_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            alt_q <= 8'h00;
        end else if (hready) begin
            wr_q <= hsel && htrans[1] && hwrite && haddr[7:0] == PEMUX_ADDR_ALT_SELECT;
            alt_q <= wr_q ? hwdata[7:0] : alt_q;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_reset_pins_input: assert property ($rose(rst_n) |-> port_e_oe == '0)
        else $error("pin driven after reset");
    a_irq6_single: assert property (ext_irq6_input |=> !ext_irq6_input)
        else $error("irq6 pulse too long");
    a_reload_single: assert property (timer2_reload |=> !timer2_reload)
        else $error("reload pulse too long");
    a_read_strobe_once: assert property (fifo_read_strobe |=> !fifo_read_strobe)
        else $error("read strobe pulse too long");
    a_ready_pass: assert property (($stable(waveform_ready_pins[5:2]))[*5]
        |-> waveform_ready_in[5:2] == waveform_ready_pins[5:2])
        else $error("ready level not passed");
    a_ser0_level: assert property (alt_q[3] |-> port_e_oe[3] && port_e_out[3] ==
        (serial0_mode == PEMUX_SERIAL_MODE_SYNC ? serial0_tx_data : 1'b1))
        else $error("serial 0 pin wrong");
    a_ser1_level: assert property (alt_q[4] |-> port_e_oe[4] && port_e_out[4] ==
        (serial1_mode == PEMUX_SERIAL_MODE_SYNC ? serial1_tx_data : 1'b1))
        else $error("serial 1 pin wrong");
    a_addr8_drive: assert property (alt_q[7] |-> port_e_oe[7] &&
        port_e_out[7] == waveform_addr_bit8)
        else $error("address bit 8 pin wrong");
    a_t2_overflow: assert property (alt_q[2] && $past(alt_q[2]) |-> port_e_oe[2] &&
        port_e_out[2] == $past(timer2_overflow))
        else $error("timer 2 overflow pin wrong");
    // Between clock-output ticks the timer 1 pin must not move
    a_t1_hold: assert property (alt_q[1] && $past(alt_q[1]) && !$past(clock_output_tick)
        |-> port_e_oe[1] && $stable(port_e_out[1]))
        else $error("timer 1 pin moved between ticks");
    // Two ticks in a row leave nothing pending, so the pin shows the last overflow only
    a_t1_source: assert property (alt_q[1] && $past(clock_output_tick) &&
        $past(clock_output_tick, 2) |-> port_e_out[1] == ($past(timer1_mode3) ?
        $past(timer1_low_byte_overflow) : $past(timer1_overflow)))
        else $error("timer 1 overflow pin wrong");
endmodule : pemux_port_e_monitor

bind pemux_port_e pemux_port_e_monitor #(.PIN_COUNT(PIN_COUNT)) pemux_port_e_monitor_inst (
    .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .port_e_out,
    .port_e_oe, .waveform_ready_pins, .timer2_overflow, .serial0_mode, .serial0_tx_data,
    .serial1_mode, .serial1_tx_data, .waveform_addr_bit8, .clock_output_tick,
    .timer1_overflow, .timer1_low_byte_overflow, .timer1_mode3, .ext_irq6_input, .timer2_reload,
    .fifo_read_strobe, .waveform_ready_in
);

/* pemux_board_model.sv */
// Board-side model of the port E and ready pins
`timescale 1ns/10ps
module pemux_board_model (
    // Device drive
    input wire logic [7:0] port_e_out,
    input wire logic [7:0] port_e_oe,
    // Board stimulus
    input wire logic [7:0] board_level,
    input wire logic [5:2] ready_level,
    input wire logic rd_active,
    input wire logic wr_active,
    input wire logic [3:2] polarity,
    // Pin levels seen by the device
    output logic [7:0] port_e_in,
    output logic [5:0] waveform_ready_pins
);
    // Board drive is weak, so a pin the device drives shows the device level
    assign port_e_in = (port_e_oe & port_e_out) | (~port_e_oe & board_level);
    assign waveform_ready_pins[0] = rd_active ~^ polarity[3];
    assign waveform_ready_pins[1] = wr_active ~^ polarity[2];
    assign waveform_ready_pins[5:2] = ready_level;
endmodule : pemux_board_model

/* pemux_port_e_tb.sv */
// Self-checking bench for the port E pin multiplexer
`timescale 1ns/10ps
module pemux_port_e_tb;
    import pemux_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd_val;
    logic hreadyout, hresp, irq, irq6, reload, rd_stb, wr_stb;
    logic [7:0] port_e_in, port_e_out, port_e_oe, bl, oe;
    logic [5:0] ready_pins, ready_in;
    logic [7:0] board = 8'h00;
    logic [3:0] rdy = 4'h0;
    logic [15:0] cs = 16'h0;
    logic [1:0] pol = 2'h3;
    logic rnd_on = 1'b0;
    logic rd_act = 1'b0;
    logic wr_act = 1'b0;
    logic rd_done = 1'b0;
    logic [31:0] rd_q[$];
    logic [3:0] ev_q[$];
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    pemux_port_e pemux_port_e_inst (
        .core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .port_e_in, .port_e_out,
        .port_e_oe, .waveform_ready_pins(ready_pins), .clock_output_tick(cs[1]),
        .timer1_overflow(cs[0]), .timer1_low_byte_overflow(cs[2]), .timer1_mode3(cs[3]),
        .timer2_overflow(cs[4]), .serial0_mode(cs[6:5]), .serial0_tx_data(cs[7]),
        .serial1_mode(cs[9:8]), .serial1_tx_data(cs[10]), .waveform_addr_bit8(cs[11]),
        .ext_irq6_input(irq6), .timer2_reload(reload), .fifo_read_strobe(rd_stb),
        .fifo_write_strobe(wr_stb), .waveform_ready_in(ready_in)
    );
    pemux_board_model pemux_board_model_inst (
        .port_e_out, .port_e_oe, .board_level(board), .ready_level(rdy), .rd_active(rd_act),
        .wr_active(wr_act), .polarity(pol), .port_e_in, .waveform_ready_pins(ready_pins)
    );
    always #50 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd_val = hrdata;
    endtask : bus
    task automatic note(input logic [31:0] v, input logic [31:0] e);
        rd_q.push_back(e);
        rd_val = v;
        rd_done = 1'b1;
    endtask : note
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        note(rd_val, e);
    endtask : rd
    // Pin events take three edges to surface; six leaves margin
    task automatic drv(input logic [7:0] b, input logic r, input logic w, input logic [3:0] e);
        board <= b;
        rd_act <= r;
        wr_act <= w;
        if (e != 4'h0) ev_q.push_back(e);
        repeat (6) @(posedge core_clk);
    endtask : drv
    ////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        cs <= rnd_on ? 16'($urandom) : 16'h0;
        if (cyc[3:0] == 4'h0) rdy <= 4'($urandom);
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end
    always @(negedge core_clk) begin
        if (rd_done) begin
            chk(rd_val, rd_q.size() > 0 ? rd_q.pop_front() : 32'hx);
            chk({31'h0, hresp}, 32'h0);
            rd_done = 1'b0;
        end
        if ({wr_stb, rd_stb, reload, irq6} !== 4'h0) begin
            chk({wr_stb, rd_stb, reload, irq6}, ev_q.size() > 0 ? ev_q.pop_front() : 4'hx);
        end
    end
    initial begin
        void'($urandom(67351));
        bl = 8'($urandom);
        oe = 8'($urandom);
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        drv(bl, 1'b0, 1'b0, 4'h0);
        rd(PEMUX_ADDR_ALT_SELECT, 32'h0);
        rd(PEMUX_ADDR_PORT_IN, {24'h0, bl});
        bus(1'b1, PEMUX_ADDR_PORT_OE, {24'h0, oe});
        bus(1'b1, PEMUX_ADDR_PORT_OUT, 32'hc3);
        drv(bl, 1'b0, 1'b0, 4'h0);
        rd(PEMUX_ADDR_PORT_IN, {24'h0, (oe & 8'hc3) | (~oe & bl)});
        bus(1'b1, PEMUX_ADDR_PORT_OE, 32'h0);
        $display("test gpio done");
        bus(1'b1, PEMUX_ADDR_IRQ_MASK, 32'hf);
        drv(8'h00, 1'b0, 1'b0, 4'h0);
        bus(1'b1, PEMUX_ADDR_ALT_SELECT, 32'h60);
        drv(8'h20, 1'b0, 1'b0, 4'h1);
        drv(8'h00, 1'b0, 1'b0, 4'h0);
        note(irq, 32'h1);
        rd(PEMUX_ADDR_IRQ_STATUS, 32'h1);
        drv(8'h40, 1'b0, 1'b0, 4'h0);
        drv(8'h00, 1'b0, 1'b0, 4'h0);
        bus(1'b1, PEMUX_ADDR_TIMER2_CONTROL, 32'h1 << PEMUX_TIMER2_CONTROL_EXT_ENABLE_BIT);
        drv(8'h40, 1'b0, 1'b0, 4'h0);
        drv(8'h00, 1'b0, 1'b0, 4'h2);
        rd(PEMUX_ADDR_IRQ_STATUS, 32'h2);
        $display("test edge inputs done");
        // Polarity only changes with slave FIFO mode off, so no false strobe edge
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, PEMUX_ADDR_IFACE_CONFIG, 32'h0);
            bus(1'b1, PEMUX_ADDR_FIFO_POLARITY, {28'h0, p[1:0], 2'h0});
            pol <= p[1:0];
            drv(8'h00, 1'b1, 1'b1, 4'h0);
            drv(8'h00, 1'b0, 1'b0, 4'h0);
            bus(1'b1, PEMUX_ADDR_IFACE_CONFIG, 32'h1);
            drv(8'h00, 1'b1, 1'b0, 4'h4);
            drv(8'h00, 1'b0, 1'b1, 4'h8);
            drv(8'h00, 1'b0, 1'b0, 4'h0);
        end
        rd(PEMUX_ADDR_IRQ_STATUS, 32'hc);
        $display("test strobes done");
        bus(1'b1, PEMUX_ADDR_ALT_SELECT, 32'hfe);
        rnd_on <= 1'b1;
        repeat (300) @(posedge core_clk);
        rnd_on <= 1'b0;
        $display("test alt outputs done");
        bus(1'b1, PEMUX_ADDR_IRQ_MASK, 32'h0);
        drv(8'h20, 1'b0, 1'b0, 4'h1);
        note(irq, 32'h0);
        rd(PEMUX_ADDR_IRQ_STATUS, 32'h1);
        rd(8'h40, 32'h0);
        @(negedge core_clk);
        chk(ev_q.size(), 32'h0);
        $display("test mask done");
        finish_test();
    end
endmodule : pemux_port_e_tb
